//--- cpu_ctl_pkg.sv
// Package for the CPU status, system register and mode decode block.
// Assumes a single core clock domain and an active-low asynchronous reset.
package cpu_ctl_pkg;

	// ---------------------------------------------------------------
	// System register numbers
	// ---------------------------------------------------------------
	localparam logic [4:0] SREG_TRAP_PC     = 5'h12;
	localparam logic [4:0] SREG_TRAP_STATUS = 5'h13;
	localparam logic [4:0] SREG_TABLE_BASE  = 5'h14;
	localparam logic [4:0] SREG_STATUS      = 5'h05;

	// ---------------------------------------------------------------
	// Status word fields
	// ---------------------------------------------------------------
	localparam int BIT_NMI_PROG  = 7;
	localparam int BIT_EXC_PROG  = 6;
	localparam int BIT_IRQ_BLOCK = 5;
	localparam int BIT_CLAMP     = 4;
	localparam int BIT_CARRY     = 3;
	localparam int BIT_WRAP      = 2;
	localparam int BIT_SIGN      = 1;
	localparam int BIT_ZERO      = 0;
	localparam int STATUS_W      = 8;
	localparam logic [7:0] STATUS_RESET = 8'h20;

	// ---------------------------------------------------------------
	// Address space
	// ---------------------------------------------------------------
	localparam int PHYS_W = 26;
	localparam logic [31:0] PC_RESET       = 32'h0000_0000;
	localparam logic [25:0] ROM_BASE_LOW   = 26'h000_0000;
	localparam logic [25:0] ROM_BASE_HIGH  = 26'h010_0000;
	localparam logic [25:0] ROM_SPAN_MASK  = 26'h3F0_0000;
	localparam logic [31:0] REG_WORD_RESET = 32'h0000_0000;

	typedef enum logic [2:0] {
		MODE_ROMLESS0,
		MODE_ROMLESS1,
		MODE_SINGLE0,
		MODE_SINGLE1,
		MODE_FLASH_PROG,
		MODE_PROHIBITED
	} op_mode_t;

endpackage

//--- boot_mode_decode.sv
// Decoder of the boot configuration pins into an operating mode.
// Assumes pins already synchronised; purely combinational.
`timescale 1ns/100ps
module boot_mode_decode (
	input  wire logic [3:0]          boot_config_pins,
	input  wire logic                prog_volt_det,
	output cpu_ctl_pkg::op_mode_t    mode
);
	// Prog voltage on the top pin wins over its logic level
	wire logic [2:0] low3 = boot_config_pins[2:0];
	wire logic       top  = boot_config_pins[3];

	always_comb
	begin
		mode = cpu_ctl_pkg::MODE_PROHIBITED;
		if (prog_volt_det)
		begin
			if (low3 == 3'h2)
				mode = cpu_ctl_pkg::MODE_FLASH_PROG; // [RULE18]
		end
		else if (!top)
		begin
			case (low3)                               // [RULE12]
				3'h0:    mode = cpu_ctl_pkg::MODE_ROMLESS0;
				3'h1:    mode = cpu_ctl_pkg::MODE_ROMLESS1;
				3'h2:    mode = cpu_ctl_pkg::MODE_SINGLE0;
				3'h3:    mode = cpu_ctl_pkg::MODE_SINGLE1;
				default: mode = cpu_ctl_pkg::MODE_PROHIBITED;
			endcase
		end
	end
endmodule

//--- cpu_ctl.sv
// CPU control state: status word, trap save and table base registers,
// boot mode latch and address folding.
// Assumes the pipeline gives one-cycle event pulses and sysreg accesses.
//
// Notes on behaviour
// [RULE1] Illegal opcode trap copies PC and status into registers 18, 19.
// [RULE2] Register 20 holds the table-call base used to form the target.
// [RULE3] System registers reached only by sysreg load and store by number.
// [RULE4] Status bits 31 to 8 always read zero.
// [RULE5] Bit 7 set on NMI accept; blocks all nested interrupts.
// [RULE6] Bit 6 set on any exception; interrupts still acceptable.
// [RULE7] Bit 5 set blocks maskable interrupts.
// [RULE8] Bit 4 set on saturating overflow, otherwise held.
// [RULE9] Bit 3 follows carry or borrow of the operation.
// [RULE10] Bit 2 follows overflow of the operation.
// [RULE11] Bit 1 follows result sign; bit 0 follows zero result.
// [RULE12] Four pins select ROMless 0/1, single-chip 0/1; others prohibited.
// [RULE13] Board holds the pins fixed; changes after startup unsupported.
// [RULE14] Single-chip 0: pins are ports, boot internal ROM at zero.
// [RULE15] Single-chip 1: bus pins control, boot external, ROM at 100000H.
// [RULE16] ROMless modes: bus control, external boot, internal ROM unreachable.
// [RULE17] Bus 16-bit in ROMless 0 and single-chip 1, 8-bit in ROMless 1.
// [RULE18] Programming voltage plus single-chip 0 pattern enters flash mode.
// [RULE19] Only the low 26 address bits form the physical address.
// [RULE20] PC top 6 bits zero; carries out of bit 25 dropped.
// [RULE21] Software keeps branch targets out of the peripheral area.
// [RULE22] Operand addresses wrap modulo 32 bits.
// [RULE23] PC bit 0 always zero.
// [RULE24] Pins sampled during reset; decoded mode held until next reset. Code latches on the third edge after release.
`timescale 1ns/100ps
module cpu_ctl (
	input  wire logic        ref_clk,
	input  wire logic        rst_n,
	// Boot configuration
	input  wire logic [3:0]  boot_config_pins,
	input  wire logic        prog_volt_det,
	// Sysreg access
	input  wire logic        sysreg_load_instr,
	input  wire logic        sysreg_store_instr,
	input  wire logic [4:0]  sysreg_num,
	input  wire logic [31:0] sysreg_wdata,
	output logic      [31:0] sysreg_rdata,
	// Flag update from the ALU
	input  wire logic        flags_we,
	input  wire logic        alu_carry,
	input  wire logic        alu_overflow,
	input  wire logic [31:0] alu_result,
	input  wire logic        sat_op,
	// Events
	input  wire logic        illegal_op_trap,
	input  wire logic        nmi_accept,
	input  wire logic        exc_taken,
	input  wire logic        irq_req,
	output logic             irq_accept_ok,
	output logic             nmi_in_progress,
	output logic             exc_in_progress,
	output logic             maskable_irq_block,
	// Program counter
	input  wire logic        pc_load,
	input  wire logic [31:0] pc_target,
	input  wire logic        pc_step,
	input  wire logic [31:0] pc_offset,
	output logic      [31:0] pc,
	input  wire logic [31:0] table_offset,
	output logic      [31:0] table_call_addr,
	// Operand addressing
	input  wire logic [31:0] op_base,
	input  wire logic [31:0] op_disp,
	output logic      [31:0] op_addr,
	output logic      [25:0] op_phys_addr,
	// Mode results
	output logic      [2:0]  op_mode,
	output logic             bus_pins_control,
	output logic             bus_width_16,
	output logic             int_rom_enable,
	output logic      [25:0] int_rom_base,
	output logic             flash_prog_mode,
	output logic             mode_prohibited
);

	// ---------------------------------------------------------------
	// Pin synchronisers and mode latch
	// ---------------------------------------------------------------
	logic [4:0] pin_s1_q;
	logic [4:0] pin_s2_q;
	logic       rst_seen_q;
	cpu_ctl_pkg::op_mode_t mode_q;
	cpu_ctl_pkg::op_mode_t mode_dec;

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pin_s1_q <= 5'h00;
			pin_s2_q <= 5'h00;
		end
		else
		begin
			pin_s1_q <= {prog_volt_det, boot_config_pins};
			pin_s2_q <= pin_s1_q;
		end
	end

	boot_mode_decode u_dec (
		.boot_config_pins (pin_s2_q[3:0]),
		.prog_volt_det    (pin_s2_q[4]),
		.mode             (mode_dec)
	);

	// Capture once just after release: async reset cannot load a port,
	// so the first two edges fill the synchroniser, the third latches.
	logic [1:0] cap_cnt_q;
	wire logic  cap_now = !rst_seen_q && (cap_cnt_q == 2'h2);

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cap_cnt_q  <= 2'h0;
			rst_seen_q <= 1'b0;
			mode_q     <= cpu_ctl_pkg::MODE_PROHIBITED;
		end
		else
		begin
			if (!rst_seen_q && cap_cnt_q != 2'h2)
				cap_cnt_q <= cap_cnt_q + 2'h1;
			if (cap_now)
			begin
				mode_q     <= mode_dec; // [RULE24]
				rst_seen_q <= 1'b1;     // [RULE13]
			end
		end
	end

	wire logic is_rl0 = (mode_q == cpu_ctl_pkg::MODE_ROMLESS0);
	wire logic is_rl1 = (mode_q == cpu_ctl_pkg::MODE_ROMLESS1);
	wire logic is_sc0 = (mode_q == cpu_ctl_pkg::MODE_SINGLE0);
	wire logic is_sc1 = (mode_q == cpu_ctl_pkg::MODE_SINGLE1);

	assign op_mode          = mode_q;
	assign flash_prog_mode  = (mode_q == cpu_ctl_pkg::MODE_FLASH_PROG);
	assign mode_prohibited  = (mode_q == cpu_ctl_pkg::MODE_PROHIBITED);
	assign bus_pins_control = is_rl0 || is_rl1 || is_sc1; // [RULE14] [RULE15] [RULE16]
	assign int_rom_enable   = is_sc0 || is_sc1;           // [RULE16]
	assign int_rom_base     = is_sc1 ? cpu_ctl_pkg::ROM_BASE_HIGH
	                                 : cpu_ctl_pkg::ROM_BASE_LOW; // [RULE14] [RULE15]
	assign bus_width_16     = is_rl0 || is_sc1;           // [RULE17]

	// ---------------------------------------------------------------
	// Status word
	// ---------------------------------------------------------------
	logic [7:0] status_q;
	logic [7:0] status_d;
	wire logic  ld_status = sysreg_load_instr
	                        && sysreg_num == cpu_ctl_pkg::SREG_STATUS;
	wire logic  res_zero  = (alu_result == 32'h0000_0000);

	always_comb
	begin
		status_d = status_q;
		if (ld_status)
			status_d = sysreg_wdata[7:0]; // [RULE3]
		if (flags_we)
		begin
			status_d[cpu_ctl_pkg::BIT_CARRY] = alu_carry;       // [RULE9]
			status_d[cpu_ctl_pkg::BIT_WRAP]  = alu_overflow;    // [RULE10]
			status_d[cpu_ctl_pkg::BIT_SIGN]  = alu_result[31];  // [RULE11]
			status_d[cpu_ctl_pkg::BIT_ZERO]  = res_zero;        // [RULE11]
			if (sat_op && alu_overflow)
				status_d[cpu_ctl_pkg::BIT_CLAMP] = 1'b1;      // [RULE8]
		end
		// Hardware events set after any software load, so set wins
		if (nmi_accept)
			status_d[cpu_ctl_pkg::BIT_NMI_PROG] = 1'b1;         // [RULE5]
		if (exc_taken || illegal_op_trap)
			status_d[cpu_ctl_pkg::BIT_EXC_PROG] = 1'b1;         // [RULE6]
	end

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			status_q <= cpu_ctl_pkg::STATUS_RESET;
		else
			status_q <= status_d;
	end

	wire logic [31:0] status_word = {24'h000000, status_q}; // [RULE4]

	assign nmi_in_progress    = status_q[cpu_ctl_pkg::BIT_NMI_PROG];
	assign exc_in_progress    = status_q[cpu_ctl_pkg::BIT_EXC_PROG];
	assign maskable_irq_block = status_q[cpu_ctl_pkg::BIT_IRQ_BLOCK];
	// Exception bit deliberately not in this term
	assign irq_accept_ok = irq_req && !nmi_in_progress
	                       && !maskable_irq_block; // [RULE5] [RULE6] [RULE7]

	// ---------------------------------------------------------------
	// Program counter
	// ---------------------------------------------------------------
	logic [25:0] pc_q;
	wire logic [25:0] pc_sum = pc_q + pc_offset[25:0]; // [RULE20]
	wire logic [25:0] pc_d   = pc_load ? pc_target[25:0]
	                         : pc_step ? pc_sum : pc_q;

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			pc_q <= cpu_ctl_pkg::PC_RESET[25:0];
		else
			pc_q <= {pc_d[25:1], 1'b0}; // [RULE23]
	end

	assign pc = {6'h00, pc_q}; // [RULE20]

	// ---------------------------------------------------------------
	// Trap save and table base
	// ---------------------------------------------------------------
	logic [31:0] trap_saved_pc_q;
	logic [31:0] trap_saved_status_q;
	logic [31:0] table_call_base_q;

	function automatic logic ld_hit(input logic [4:0] n);
		ld_hit = sysreg_load_instr && sysreg_num == n;
	endfunction

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			trap_saved_pc_q     <= cpu_ctl_pkg::REG_WORD_RESET;
			trap_saved_status_q <= cpu_ctl_pkg::REG_WORD_RESET;
			table_call_base_q   <= cpu_ctl_pkg::REG_WORD_RESET;
		end
		else
		begin
			if (illegal_op_trap)
			begin
				trap_saved_pc_q     <= pc;          // [RULE1]
				trap_saved_status_q <= status_word; // [RULE1]
			end
			else
			begin
				if (ld_hit(cpu_ctl_pkg::SREG_TRAP_PC))
					trap_saved_pc_q <= sysreg_wdata;
				if (ld_hit(cpu_ctl_pkg::SREG_TRAP_STATUS))
					trap_saved_status_q <= sysreg_wdata;
			end
			if (ld_hit(cpu_ctl_pkg::SREG_TABLE_BASE))
				table_call_base_q <= sysreg_wdata; // [RULE2]
		end
	end

	assign table_call_addr = table_call_base_q + table_offset; // [RULE2]

	// ---------------------------------------------------------------
	// Sysreg read
	// ---------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			sysreg_rdata <= cpu_ctl_pkg::REG_WORD_RESET;
		else if (sysreg_store_instr)
		begin
			case (sysreg_num) // [RULE3]
				cpu_ctl_pkg::SREG_STATUS:      sysreg_rdata <= status_word;
				cpu_ctl_pkg::SREG_TRAP_PC:     sysreg_rdata <= trap_saved_pc_q;
				cpu_ctl_pkg::SREG_TRAP_STATUS: sysreg_rdata <= trap_saved_status_q;
				cpu_ctl_pkg::SREG_TABLE_BASE:  sysreg_rdata <= table_call_base_q;
				default:                       sysreg_rdata <= 32'h0000_0000;
			endcase
		end
	end

	// ---------------------------------------------------------------
	// Operand address folding
	// ---------------------------------------------------------------
	assign op_addr      = op_base + op_disp;   // [RULE22]
	assign op_phys_addr = op_addr[25:0];       // [RULE19]

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	a_trap_save_pc: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE1]
		illegal_op_trap |=> trap_saved_pc_q == $past(pc))
		else $error("trap pc not saved");
	a_status_top_zero: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE4]
		status_word[31:8] == 24'h000000)
		else $error("status upper bits not zero");
	a_nmi_blocks: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE5]
		nmi_accept |=> nmi_in_progress && !irq_accept_ok)
		else $error("nmi did not block irq");
	a_exc_allows: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE6]
		exc_in_progress && irq_req && !nmi_in_progress
		&& !maskable_irq_block |-> irq_accept_ok)
		else $error("exception bit blocked irq");
	a_clamp_sticky: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE8]
		status_q[cpu_ctl_pkg::BIT_CLAMP] && !$past(ld_status)
		|-> $past(status_q[cpu_ctl_pkg::BIT_CLAMP]) || $past(sat_op && flags_we))
		else $error("clamp flag set without cause");
	a_carry_follow: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE9]
		flags_we |=> status_q[cpu_ctl_pkg::BIT_CARRY] == $past(alu_carry))
		else $error("carry flag wrong");
	a_zero_follow: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE11]
		flags_we |=> status_q[cpu_ctl_pkg::BIT_ZERO] == $past(res_zero))
		else $error("zero flag wrong");
	a_pc_even_top: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE23]
		pc[0] == 1'b0 && pc[31:26] == 6'h00)
		else $error("pc odd or above 26 bits");
	a_mode_held: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE24]
		rst_seen_q ##1 rst_seen_q |-> $stable(mode_q))
		else $error("mode changed after capture");
	a_bus_width: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE17]
		is_rl1 |-> !bus_width_16 && bus_pins_control)
		else $error("romless1 bus wrong");
	a_clamp_set: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE8]
		flags_we && sat_op && alu_overflow |=> status_q[cpu_ctl_pkg::BIT_CLAMP])
		else $error("clamp flag not set on overflow");
	a_wrap_follow: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE10]
		flags_we |=> status_q[cpu_ctl_pkg::BIT_WRAP] == $past(alu_overflow))
		else $error("overflow flag wrong");
	a_sign_follow: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE11]
		flags_we |=> status_q[cpu_ctl_pkg::BIT_SIGN] == $past(alu_result[31]))
		else $error("sign flag wrong");
	a_exc_sets: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE6]
		exc_taken || illegal_op_trap |=> exc_in_progress)
		else $error("exception bit not set");
	a_irq_masked: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE7]
		maskable_irq_block |-> !irq_accept_ok)
		else $error("maskable irq accepted while blocked");
	a_trap_status: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE1]
		illegal_op_trap |=> trap_saved_status_q == $past(status_word))
		else $error("trap status not saved");
	a_pc_step_wrap: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE20]
		pc_step && !pc_load |=> pc[25:1] == $past(pc[25:1] + pc_offset[25:1]))
		else $error("pc step did not wrap in 26 bits");
	a_rdata_held: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE3]
		!sysreg_store_instr |=> $stable(sysreg_rdata))
		else $error("read data changed without store");
	a_sc0_ports: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE14]
		is_sc0 |-> !bus_pins_control && int_rom_enable && int_rom_base == 26'h000_0000)
		else $error("single-chip 0 setup wrong");
	a_sc1_reloc: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE15]
		is_sc1 |-> bus_pins_control && int_rom_enable && int_rom_base == 26'h010_0000)
		else $error("single-chip 1 setup wrong");
	a_romless_norom: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE16]
		is_rl0 || is_rl1 |-> bus_pins_control && !int_rom_enable)
		else $error("romless mode reached internal rom");
endmodule

//--- boot_strap_model.sv
// Board strapping model for the boot configuration pins.
// Assumes the bench changes the selection only just before or while reset is held,
// except where a scenario breaks that on purpose.
`timescale 1ns/100ps
module boot_strap_model (
	input  wire logic [3:0] strap_sel,
	input  wire logic       hv_sel,
	output logic      [3:0] boot_config_pins,
	output logic            prog_volt_det
);
	// Pins are held at fixed levels by resistors on the board
	assign boot_config_pins = strap_sel;
	// High voltage on the top pin is seen through its own detector
	assign prog_volt_det = hv_sel;
endmodule

//--- cpu_ctl_tb_top.sv
// Self-checking bench for the CPU control block.
// Assumes the strapping model drives the boot pins; all else from here.
`timescale 1ns/100ps
module cpu_ctl_tb_top;
	logic        ref_clk = 1'b0;
	logic        rst_n = 1'b0;
	logic [3:0]  strap_sel = 4'h2;
	logic        hv_sel = 1'b0;
	wire  [3:0]  boot_config_pins;
	wire         prog_volt_det;
	logic        sysreg_load_instr = 1'b0, sysreg_store_instr = 1'b0;
	logic [4:0]  sysreg_num = 5'h00;
	logic [31:0] sysreg_wdata = 32'h0, alu_result = 32'h0;
	logic        flags_we = 1'b0, alu_carry = 1'b0, alu_overflow = 1'b0;
	logic        sat_op = 1'b0, illegal_op_trap = 1'b0, nmi_accept = 1'b0;
	logic        exc_taken = 1'b0, irq_req = 1'b0;
	logic        pc_load = 1'b0, pc_step = 1'b0;
	logic [31:0] pc_target = 32'h0, pc_offset = 32'h0, table_offset = 32'h0;
	logic [31:0] op_base = 32'h0, op_disp = 32'h0;
	logic [31:0] sysreg_rdata, pc, table_call_addr, op_addr;
	logic [25:0] op_phys_addr, int_rom_base;
	logic [2:0]  op_mode;
	logic        irq_accept_ok, nmi_in_progress, exc_in_progress;
	logic        maskable_irq_block, bus_pins_control, bus_width_16;
	logic        int_rom_enable, flash_prog_mode, mode_prohibited;
	logic [31:0] w, pcx;
	logic [7:0]  st;
	logic [3:0]  pats [6] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h9, 4'h2};
	cpu_ctl_pkg::op_mode_t m;
	int          miscompares = 0;
	int          checks_done = 0;

	boot_strap_model strap (.strap_sel, .hv_sel, .boot_config_pins,
		.prog_volt_det);
	cpu_ctl DUT (.ref_clk, .rst_n, .boot_config_pins, .prog_volt_det,
		.sysreg_load_instr, .sysreg_store_instr, .sysreg_num, .sysreg_wdata,
		.sysreg_rdata, .flags_we, .alu_carry, .alu_overflow, .alu_result,
		.sat_op, .illegal_op_trap, .nmi_accept, .exc_taken, .irq_req,
		.irq_accept_ok, .nmi_in_progress, .exc_in_progress,
		.maskable_irq_block, .pc_load, .pc_target, .pc_step, .pc_offset,
		.pc, .table_offset, .table_call_addr, .op_base, .op_disp, .op_addr,
		.op_phys_addr, .op_mode, .bus_pins_control, .bus_width_16,
		.int_rom_enable, .int_rom_base, .flash_prog_mode, .mode_prohibited);

	always #12.5 ref_clk = ~ref_clk;

	// ---------------------------------------------------------------
	// Helpers
	// ---------------------------------------------------------------
	task automatic tick();
		@(posedge ref_clk);
		#2;
	endtask

	task automatic check(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		checks_done++;
		if (got !== exp)
		begin
			miscompares++;
			$display("FAIL %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic sr_load(input logic [4:0] n, input logic [31:0] d);
		sysreg_load_instr = 1'b1;
		sysreg_num = n;
		sysreg_wdata = d;
		tick();
		sysreg_load_instr = 1'b0;
	endtask

	// Read data lands on the edge that takes the store pulse
	task automatic sr_read(input logic [4:0] n, input logic [31:0] exp,
		input string what);
		sysreg_store_instr = 1'b1;
		sysreg_num = n;
		tick();
		sysreg_store_instr = 1'b0;
		check(what, exp, sysreg_rdata);
	endtask

	// Mode latch needs three edges after release, four given
	task automatic do_reset();
		rst_n = 1'b0;
		repeat (16) tick();
		rst_n = 1'b1;
		repeat (4) tick();
		st = cpu_ctl_pkg::STATUS_RESET;
	endtask

	function automatic cpu_ctl_pkg::op_mode_t exp_mode(logic [3:0] p,
		logic hv);
		if (hv)
			return (p == 4'h2) ? cpu_ctl_pkg::MODE_FLASH_PROG
				: cpu_ctl_pkg::MODE_PROHIBITED;
		case (p)
			4'h0: return cpu_ctl_pkg::MODE_ROMLESS0;
			4'h1: return cpu_ctl_pkg::MODE_ROMLESS1;
			4'h2: return cpu_ctl_pkg::MODE_SINGLE0;
			4'h3: return cpu_ctl_pkg::MODE_SINGLE1;
			default: return cpu_ctl_pkg::MODE_PROHIBITED;
		endcase
	endfunction

	task automatic report_and_stop();
		$display("checks %0d miscompares %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	initial
	begin
		repeat (20000) @(posedge ref_clk);
		miscompares++;
		report_and_stop();
	end

	// ---------------------------------------------------------------
	// Scenarios
	// ---------------------------------------------------------------
	initial
	begin
		w = $urandom(52);
		for (int i = 0; i < 6; i++)
		begin
			strap_sel = pats[i];
			hv_sel = (i == 5);
			do_reset();
			m = exp_mode(pats[i], hv_sel);
			check("mode", m, op_mode);
			check("flash", m == cpu_ctl_pkg::MODE_FLASH_PROG, flash_prog_mode);
			check("prohib", m == cpu_ctl_pkg::MODE_PROHIBITED, mode_prohibited);
			if (i < 5)
			begin
				check("bus ctl", i inside {0, 1, 3}, bus_pins_control);
				check("rom en", i inside {2, 3}, int_rom_enable);
				check("rom base", (i == 3) ? 26'h010_0000 : 26'h0, int_rom_base);
				if (i != 2)
					check("width16", i == 0 || i == 3, bus_width_16);
			end
			// Breaking the fixed strapping must not disturb the latch
			strap_sel = ~strap_sel;
			repeat (4) tick();
			check("mode held", m, op_mode);
		end
		strap_sel = 4'h2;
		hv_sel = 1'b0;
		do_reset();
		sr_read(cpu_ctl_pkg::SREG_STATUS, {24'h0, st}, "status rst");
		for (int i = 0; i < 10; i++)
		begin
			w = (i == 0) ? 32'hFFFF_FF40 : $urandom();
			irq_req = (i == 0) | w[8];
			sr_load(cpu_ctl_pkg::SREG_STATUS, w);
			st = w[7:0];
			sr_read(cpu_ctl_pkg::SREG_STATUS, {24'h0, st}, "status");
			check("nmi bit", st[7], nmi_in_progress);
			check("exc bit", st[6], exc_in_progress);
			check("irq blk", st[5], maskable_irq_block);
			check("irq ok", irq_req & ~st[7] & ~st[5], irq_accept_ok);
		end
		irq_req = 1'b1;
		sr_load(cpu_ctl_pkg::SREG_STATUS, 32'h0);
		nmi_accept = 1'b1;
		tick();
		nmi_accept = 1'b0;
		check("nmi set", 1'b1, nmi_in_progress);
		check("irq nmi", 1'b0, irq_accept_ok);
		sr_load(cpu_ctl_pkg::SREG_STATUS, 32'h0);
		exc_taken = 1'b1;
		tick();
		exc_taken = 1'b0;
		check("exc set", 1'b1, exc_in_progress);
		check("irq exc", 1'b1, irq_accept_ok);
		sr_load(cpu_ctl_pkg::SREG_STATUS, 32'h0);
		st = 8'h00;
		for (int i = 0; i < 16; i++)
		begin
			w = $urandom();
			alu_carry = w[0];
			alu_overflow = w[1];
			sat_op = w[2];
			alu_result = (i % 4 == 0) ? 32'h0 : $urandom();
			flags_we = 1'b1;
			tick();
			flags_we = 1'b0;
			st[4] = st[4] | (sat_op & alu_overflow);
			st[3:0] = {alu_carry, alu_overflow, alu_result[31],
				alu_result == 32'h0};
			sr_read(cpu_ctl_pkg::SREG_STATUS, {24'h0, st}, "flags");
		end
		pc_target = $urandom() & 32'hFDFF_FFFF;
		pc_load = 1'b1;
		tick();
		pc_load = 1'b0;
		pcx = pc_target & 32'h03FF_FFFE;
		check("pc load", pcx, pc);
		illegal_op_trap = 1'b1;
		tick();
		illegal_op_trap = 1'b0;
		sr_read(cpu_ctl_pkg::SREG_TRAP_PC, pcx, "trap pc");
		sr_read(cpu_ctl_pkg::SREG_TRAP_STATUS, {24'h0, st}, "trap st");
		st[6] = 1'b1;
		sr_read(cpu_ctl_pkg::SREG_STATUS, {24'h0, st}, "trap exc");
		// Targets stay clear of the peripheral area at the top
		pc_target = 32'h03FF_EFF0;
		pc_load = 1'b1;
		tick();
		pc_load = 1'b0;
		pc_offset = 32'h1020;
		pc_step = 1'b1;
		tick();
		check("pc wrap", 32'h10, pc);
		pc_offset = 32'hFFFF_EFE0;
		tick();
		pc_step = 1'b0;
		check("pc borrow", 32'h03FF_EFF0, pc);
		w = $urandom();
		sr_load(cpu_ctl_pkg::SREG_TABLE_BASE, w);
		sr_read(cpu_ctl_pkg::SREG_TABLE_BASE, w, "table base");
		table_offset = $urandom();
		#1;
		check("table addr", w + table_offset, table_call_addr);
		sr_load(5'h07, 32'hFFFF_FFFF);
		sr_read(5'h07, 32'h0, "reserved");
		for (int i = 0; i < 6; i++)
		begin
			op_base = (i == 0) ? 32'hFFFF_FFF0 : $urandom();
			op_disp = (i == 0) ? 32'h20 : $urandom();
			tick();
			w = op_base + op_disp;
			check("op addr", w, op_addr);
			check("op phys", {6'h0, w[25:0]}, op_phys_addr);
		end
		report_and_stop();
	end
endmodule
